// *** rtl/gde_pkg.sv ***
package gde_pkg;
  // apb register byte addresses
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_ZERO = 8'h04;
  localparam logic [7:0] ADDR_SPAN = 8'h08;
  localparam logic [7:0] ADDR_CMD = 8'h0c;
  localparam logic [7:0] ADDR_STATUS = 8'h10;
  localparam logic [7:0] ADDR_READING = 8'h14;

  // register field positions and reset values
  localparam int CTRL_MODE_BIT = 0;
  localparam int CTRL_GAS_LSB = 1;
  localparam int CTRL_HYST_BIT = 3;
  localparam logic [3:0] CTRL_RESET = 4'h9;
  localparam logic [7:0] ZERO_RESET = 8'h00;
  localparam logic [7:0] SPAN_RESET = 8'h40;
  localparam int CMD_CAPTURE_BIT = 0;
  localparam int CMD_STORE_BIT = 1;
  localparam int STATUS_CODE_LSB = 8;
  localparam int STATUS_STATE_LSB = 16;

  // span of 64 is unity gain
  localparam int SPAN_SHIFT = 6;

  localparam logic [1:0] GAS_HYDROGEN = 2'h0;
  localparam logic [1:0] GAS_METHANE = 2'h1;
  localparam logic [1:0] GAS_PROPANE = 2'h2;

  // reading unit sizes in ppm and range limits in ppm
  localparam int RU_PPM_HYDROGEN = 400;
  localparam int RU_PPM_METHANE = 400;
  localparam int RU_PPM_PROPANE = 200;
  localparam int MAX_PPM_HYDROGEN = 20000;
  localparam int MAX_PPM_METHANE = 25000;
  localparam int MAX_PPM_PROPANE = 10000;
  localparam logic [7:0] MAX_RU_HYDROGEN =
    8'(MAX_PPM_HYDROGEN / RU_PPM_HYDROGEN);
  localparam logic [7:0] MAX_RU_METHANE = 8'(MAX_PPM_METHANE / RU_PPM_METHANE);
  localparam logic [7:0] MAX_RU_PROPANE = 8'(MAX_PPM_PROPANE / RU_PPM_PROPANE);

  // output converter, 78.4 mv per step
  localparam int DAC_BITS = 6;
  localparam logic [5:0] DAC_MAX = 6'h3f;
  localparam logic [5:0] SAFETY_OFFSET = 6'h07;
  localparam logic [5:0] STEP_ERROR = 6'h00;
  localparam logic [5:0] STEP_NORMAL = 6'h10;
  localparam logic [5:0] STEP_WARNING = 6'h20;
  localparam logic [5:0] STEP_ALARM = 6'h30;

  localparam logic [7:0] HYST_BAND = 8'h01;

  // linearising table, nine knots over the normalised signal
  localparam logic [8:0][7:0] LIN_TABLE = {
    8'h78, 8'h4c, 8'h30, 8'h1e, 8'h12, 8'h0a, 8'h05, 8'h02, 8'h00
  };

  typedef enum logic [4:0] {
    ST_WARMUP = 5'b00001,
    ST_NORMAL = 5'b00010,
    ST_WARNING = 5'b00100,
    ST_ALARM = 5'b01000,
    ST_ERROR = 5'b10000
  } gde_state_t;
endpackage : gde_pkg

// *** rtl/gde_encoder.sv ***
// The APB slave port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
module gde_encoder
  import gde_pkg::*;
(
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic clkEn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic sampleValid,
  input wire logic [7:0] sampleRaw,
  input wire logic warmupActive,
  input wire logic errorActive,
  input wire logic warningActive,
  input wire logic alarmActive,
  output logic [5:0] dacCode,
  output logic nvStoreReq,
  output logic [7:0] nvSpanData
);

  function automatic logic [7:0] sat8(input logic [15:0] v);
    sat8 = (v > 16'h00ff) ? 8'hff : v[7:0];
  endfunction : sat8

  function automatic logic [7:0] tblAt(input logic [3:0] idx);
    tblAt = LIN_TABLE[idx];
  endfunction : tblAt

  function automatic logic [7:0] maxReadingUnit(input logic [1:0] gas);
    logic [7:0] m;
    m = MAX_RU_HYDROGEN;
    if (gas == GAS_METHANE) begin
      m = MAX_RU_METHANE;
    end else if (gas == GAS_PROPANE) begin
      m = MAX_RU_PROPANE;
    end
    maxReadingUnit = m;
  endfunction : maxReadingUnit

  logic [3:0] ctrl_reg;
  logic [7:0] zero_reg;
  logic [7:0] span_reg;
  logic [7:0] raw_reg;
  logic [7:0] lin_reg;
  logic linValid_reg;
  logic [9:0] avg_reg;
  logic avgValid_reg;
  logic [7:0] reading_reg;
  gde_state_t state_reg;
  gde_state_t state_next;
  logic [5:0] dac_next;

  // apb decode
  wire setupPhase = psel & ~penable;
  wire accessDone = psel & penable & pready;
  wire wrDone = accessDone & pwrite;
  wire hitCtrl = (paddr == ADDR_CTRL);
  wire hitZero = (paddr == ADDR_ZERO);
  wire hitSpan = (paddr == ADDR_SPAN);
  wire hitCmd = (paddr == ADDR_CMD);
  wire hitStatus = (paddr == ADDR_STATUS);
  wire hitReading = (paddr == ADDR_READING);
  wire addrMapped = hitCtrl | hitZero | hitSpan | hitCmd | hitStatus |
                    hitReading;
  wire propMode = ctrl_reg[CTRL_MODE_BIT];
  wire [1:0] gasType = ctrl_reg[CTRL_GAS_LSB +: 2];
  wire hystEn = ctrl_reg[CTRL_HYST_BIT];
  wire captureCmd = wrDone & hitCmd & pwdata[CMD_CAPTURE_BIT];
  wire storeCmd = wrDone & hitCmd & pwdata[CMD_STORE_BIT];

  wire [31:0] statusWord = {11'h000, state_reg, 2'h0, dacCode,
                            reading_reg};
  wire [31:0] rdMux =
    hitCtrl ? {28'h0000000, ctrl_reg} :
    hitZero ? {24'h000000, zero_reg} :
    hitSpan ? {24'h000000, span_reg} :
    hitStatus ? statusWord :
    hitReading ? {24'h000000, reading_reg} :
    32'h00000000;

  // baseline removal then span, both saturating
  wire [7:0] netSig = (sampleRaw > zero_reg) ? 8'(sampleRaw - zero_reg) :
                      8'h00;
  wire [15:0] spanProd = 16'(netSig) * 16'(span_reg);
  wire [7:0] spanned = sat8(16'(spanProd >> SPAN_SHIFT));

  // segment knots and linear interpolation inside the segment
  wire [3:0] seg = {1'b0, spanned[7:5]};
  wire [4:0] frac = spanned[4:0];
  wire [7:0] knotLo = tblAt(seg);
  wire [7:0] knotHi = tblAt(4'(seg + 4'h1));
  wire [12:0] interpProd = 13'(8'(knotHi - knotLo)) * 13'(frac);
  wire [7:0] linNext = 8'(knotLo + 8'(interpProd >> 5));

  // first-order average, weight 1/4 on the new sample
  wire [9:0] avgNext = 10'(avg_reg - 10'(avg_reg >> 2) + 10'(lin_reg));
  wire [7:0] avgValue = avg_reg[9:2];

  // clamp to the gas range, expressed in reading units
  wire [7:0] ruLimit = maxReadingUnit(gasType);
  wire [7:0] ruClamped = (avgValue > ruLimit) ? ruLimit : avgValue;
  wire [7:0] ruDiff = (ruClamped > reading_reg) ?
                      8'(ruClamped - reading_reg) :
                      8'(reading_reg - ruClamped);
  // a one-unit wobble is held back to keep the output from chattering
  wire ruHold = hystEn & (ruDiff <= HYST_BAND);

  // proportional code, widened so the sum cannot wrap
  wire [8:0] propSum = 9'(SAFETY_OFFSET) + 9'(reading_reg);
  wire [5:0] propCode = (propSum > 9'(DAC_MAX)) ? DAC_MAX :
                        propSum[5:0];

  // device state, error outranks every other condition
  always_comb begin
    if (errorActive) begin
      state_next = ST_ERROR;
    end else if (warmupActive) begin
      state_next = ST_WARMUP;
    end else if (alarmActive) begin
      state_next = ST_ALARM;
    end else if (warningActive) begin
      state_next = ST_WARNING;
    end else begin
      state_next = ST_NORMAL;
    end
  end

  // output code selection
  always_comb begin
    dac_next = STEP_ERROR;
    unique case (state_reg)
      ST_ERROR: begin
        dac_next = STEP_ERROR;
      end
      ST_WARMUP: begin
        dac_next = propMode ? propCode : STEP_NORMAL;
      end
      ST_NORMAL: begin
        dac_next = propMode ? propCode : STEP_NORMAL;
      end
      ST_WARNING: begin
        // no distinct level in proportional mode
        dac_next = propMode ? propCode : STEP_WARNING;
      end
      ST_ALARM: begin
        dac_next = propMode ? propCode : STEP_ALARM;
      end
      default: begin
        dac_next = STEP_ERROR;
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end else if (clkEn) begin
      // zero wait states: answer ready in the first access cycle
      pready <= setupPhase;
      pslverr <= setupPhase & ~addrMapped;
      prdata <= (setupPhase & ~pwrite) ? rdMux : 32'h00000000;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      ctrl_reg <= CTRL_RESET;
      span_reg <= SPAN_RESET;
    end else if (clkEn) begin
      if (wrDone & hitCtrl) begin
        ctrl_reg <= pwdata[3:0];
      end
      if (wrDone & hitSpan) begin
        span_reg <= pwdata[7:0];
      end
    end
  end

  // a capture command wins over a write to the same register
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      zero_reg <= ZERO_RESET;
    end else if (clkEn) begin
      if (captureCmd) begin
        zero_reg <= raw_reg;
      end else if (wrDone & hitZero) begin
        zero_reg <= pwdata[7:0];
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      nvStoreReq <= 1'b0;
      nvSpanData <= SPAN_RESET;
    end else if (clkEn) begin
      nvStoreReq <= storeCmd;
      if (storeCmd) begin
        nvSpanData <= span_reg;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      raw_reg <= 8'h00;
      lin_reg <= 8'h00;
      linValid_reg <= 1'b0;
    end else if (clkEn) begin
      linValid_reg <= sampleValid;
      if (sampleValid) begin
        raw_reg <= sampleRaw;
        lin_reg <= linNext;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      avg_reg <= 10'h000;
      avgValid_reg <= 1'b0;
    end else if (clkEn) begin
      avgValid_reg <= linValid_reg;
      if (state_reg == ST_WARMUP) begin
        avg_reg <= 10'h000;
      end else if (linValid_reg) begin
        avg_reg <= avgNext;
      end
    end
  end

  // 8-bit unit count, the value software sees in the reading register
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      reading_reg <= 8'h00;
    end else if (clkEn) begin
      if (state_reg == ST_WARMUP) begin
        reading_reg <= 8'h00;
      end else if (avgValid_reg & ~ruHold) begin
        reading_reg <= ruClamped;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      state_reg <= ST_WARMUP;
      dacCode <= STEP_ERROR;
    end else if (clkEn) begin
      state_reg <= state_next;
      dacCode <= dac_next;
    end
  end

endmodule : gde_encoder

// *** tb/gde_reader_model.sv ***
`timescale 1ns/1ps
module gde_reader_model
  import gde_pkg::*;
(
  input wire logic [5:0] dacCode,
  input wire logic [8:0] unitPpm,
  output logic [15:0] ppm,
  output logic fault
);
  wire logic [15:0] netSteps = 16'(dacCode - SAFETY_OFFSET);
  // no offset means a dead unit or broken wiring
  assign fault = dacCode < SAFETY_OFFSET;
  // warning and alarm only show as concentration here
  assign ppm = fault ? 16'h0 : netSteps * 16'(unitPpm);
endmodule : gde_reader_model

// *** tb/gde_encoder_chk.sv ***
`timescale 1ns/1ps
module gde_encoder_chk
  import gde_pkg::*;
(
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic clkEn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic warmupActive,
  input wire logic errorActive,
  input wire logic [5:0] dacCode,
  input wire logic nvStoreReq
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (srst);
  wire setup = psel && !penable && clkEn;
  wire storeWr = psel && penable && pready && pwrite && clkEn &&
    paddr == ADDR_CMD && pwdata[CMD_STORE_BIT];
  property p_err; (errorActive && clkEn)[*3] |-> dacCode == STEP_ERROR;
  endproperty
  a_err: assert property (p_err) else $error("dac not zero");
  property p_ofs; dacCode != STEP_ERROR |-> dacCode >= SAFETY_OFFSET;
  endproperty
  a_ofs: assert property (p_ofs) else $error("dac below offset");
  property p_warm; (warmupActive && !errorActive && clkEn)[*5] |->
    dacCode inside {SAFETY_OFFSET, STEP_NORMAL};
  endproperty
  a_warm: assert property (p_warm) else $error("warmup dac");
  property p_rdy; setup |=> pready;
  endproperty
  a_rdy: assert property (p_rdy) else $error("no ready");
  property p_acc; pready |-> psel && penable ##1 !pready;
  endproperty
  a_acc: assert property (p_acc) else $error("stray ready");
  property p_unm; setup && paddr > ADDR_READING |=> pslverr && prdata == 0;
  endproperty
  a_unm: assert property (p_unm) else $error("unmapped ok");
  property p_store; storeWr |=> nvStoreReq ##1 !nvStoreReq;
  endproperty
  a_store: assert property (p_store) else $error("no store");
  property p_nvq; nvStoreReq |-> $past(storeWr);
  endproperty
  a_nvq: assert property (p_nvq) else $error("stray store");
  c_store: cover property (storeWr);
  c_unm: cover property (setup && paddr > ADDR_READING);
  c_sat: cover property (dacCode == DAC_MAX);
endmodule : gde_encoder_chk
bind gde_encoder gde_encoder_chk chk_u (.*);

// *** tb/gde_encoder_bench.sv ***
`timescale 1ns/1ps
module gde_encoder_bench
  import gde_pkg::*;
;
  typedef struct packed {
    logic m; logic [1:0] g; logic [7:0] raw; logic [3:0] st;
    logic [5:0] dac; logic [7:0] ru;
  } gde_row_t;
  // st is warmup, error, warning, alarm
  localparam gde_row_t ROWS [13] = '{
    '{1'h1, 2'h0, 8'h60, 4'h0, 6'h11, 8'h0a},
    '{1'h1, 2'h1, 8'hc0, 4'h0, 6'h37, 8'h30},
    '{1'h1, 2'h0, 8'hff, 4'h1, 6'h39, 8'h32},
    '{1'h1, 2'h2, 8'hff, 4'h2, 6'h39, 8'h32},
    '{1'h1, 2'h1, 8'hff, 4'h0, 6'h3f, 8'h3e},
    '{1'h1, 2'h3, 8'hff, 4'h0, 6'h39, 8'h32},
    '{1'h1, 2'h0, 8'h00, 4'h4, 6'h00, 8'h00},
    '{1'h0, 2'h0, 8'h60, 4'h0, 6'h10, 8'h0a},
    '{1'h0, 2'h0, 8'h60, 4'h1, 6'h30, 8'h0a},
    '{1'h0, 2'h0, 8'h60, 4'h2, 6'h20, 8'h0a},
    '{1'h0, 2'h0, 8'h00, 4'h4, 6'h00, 8'h00},
    '{1'h0, 2'h0, 8'hc0, 4'h8, 6'h10, 8'h00},
    '{1'h1, 2'h0, 8'hc0, 4'h8, 6'h07, 8'h00}};
  logic ref_clk;
  logic srst = 1'h1;
  logic clkEn = 1'h1;
  logic psel = 1'h0, penable = 1'h0, pwrite = 1'h0, sampleValid = 1'h0;
  logic [7:0] paddr = 8'h00, sampleRaw = 8'h00, nvSpanData;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic warmupActive = 1'h0, errorActive = 1'h0;
  logic warningActive = 1'h0, alarmActive = 1'h0;
  logic pready, pslverr, nvStoreReq, er, fault;
  logic [5:0] dacCode;
  logic [15:0] ppm;
  logic [1:0] gasSel = 2'h0;
  int num_errors = 0, n_compared = 0;
  gde_row_t r;
  wire logic [8:0] unitPpm = 9'(gasSel == GAS_PROPANE ? RU_PPM_PROPANE :
    gasSel == GAS_METHANE ? RU_PPM_METHANE : RU_PPM_HYDROGEN);
  gde_encoder dut_u (.*);
  gde_reader_model rdr_u (.dacCode(dacCode), .unitPpm(unitPpm),
    .ppm(ppm), .fault(fault));
  initial begin
    ref_clk = 1'h0;
    forever #12.5 ref_clk = ~ref_clk;
  end
  task report_and_stop;
    $display("errors %0d compared %0d", num_errors, n_compared);
    if (num_errors == 0 && n_compared > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : report_and_stop
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      num_errors++;
      $display("wrong value %s exp %h got %h", n, e, g);
    end
  endtask : chk
  // idle edge first so no strobe is assigned twice in one step
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'h1;
    do @(posedge ref_clk); while (pready !== 1'h1);
    rd = prdata;
    er = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask : apb
  // enough samples for the averager to settle exactly
  task feed(input logic [7:0] v);
    repeat (48) begin
      @(posedge ref_clk);
      sampleValid <= 1'h1;
      sampleRaw <= v;
    end
    @(posedge ref_clk);
    sampleValid <= 1'h0;
    repeat (6) @(posedge ref_clk);
  endtask : feed
  initial begin
    repeat (5) @(posedge ref_clk);
    srst <= 1'h0;
    for (int i = 0; i < 13; i++) begin
      r = ROWS[i];
      gasSel <= r.g;
      apb(1'h1, ADDR_CTRL, {29'h0, r.g, r.m});
      {warmupActive, errorActive, warningActive, alarmActive} <= r.st;
      feed(r.raw);
      chk("dac", r.dac, dacCode);
      chk("fault", 32'(r.dac == 6'h00), 32'(fault));
      apb(1'h0, ADDR_READING, 32'h0);
      chk("reading", r.ru, rd);
      if (r.m && r.dac != 6'h3f && r.dac != 6'h00)
        chk("ppm", 32'(r.ru) * 32'(unitPpm), ppm);
    end
    {warmupActive, gasSel} <= 3'h0;
    apb(1'h1, ADDR_CTRL, 32'h1);
    feed(8'h60);
    apb(1'h1, ADDR_CTRL, 32'h9);
    feed(8'h64);
    chk("dac", 32'h11, dacCode);
    apb(1'h1, ADDR_CTRL, 32'h1);
    feed(8'h64);
    chk("dac", 32'h12, dacCode);
    apb(1'h1, ADDR_CMD, 32'h1);
    apb(1'h0, ADDR_ZERO, 32'h0);
    chk("zero", 32'h64, rd);
    feed(8'h64);
    chk("dac", 32'h07, dacCode);
    // normal state, offset code, zero reading
    apb(1'h0, ADDR_STATUS, 32'h0);
    chk("status", 32'h00020700, rd);
    apb(1'h1, ADDR_SPAN, 32'h55);
    apb(1'h1, ADDR_CMD, 32'h2);
    // store pulse and data are launched by the edge the write lands on
    @(posedge ref_clk);
    chk("store", 32'h1, nvStoreReq);
    chk("span", 32'h55, nvSpanData);
    apb(1'h0, 8'h20, 32'h0);
    chk("slverr", 32'h1, er);
    // second reset mid-run restores defaults
    srst <= 1'h1;
    repeat (5) @(posedge ref_clk);
    srst <= 1'h0;
    chk("nvspan", 32'h40, nvSpanData);
    chk("dac", 32'h00, dacCode);
    apb(1'h0, ADDR_CTRL, 32'h0);
    chk("ctrl", 32'h9, rd);
    apb(1'h0, ADDR_SPAN, 32'h0);
    chk("span", 32'h40, rd);
    report_and_stop();
  end
  initial begin
    #250000;
    num_errors++;
    report_and_stop();
  end
endmodule : gde_encoder_bench
